//--- logic/fsp_regs.sv
// Purpose: status register pair and array write protection of a serial NOR flash
// Assumes: a command decoder on core_clk presents one finished command per cmd_valid pulse
// Notes:   power cycle is rstn; non-volatile bits come from nv_image after release
//
// Summary of operation
// - busy_flag is 1 while program, erase or status write runs, else 0.
// - with write_latch 0, status write, program and erase are refused.
// - protect_sel is non-volatile, changed only by status write, sizes protected area.
// - program and sector or block erase into the protected area are not executed.
// - whole array erase only with low protect_sel 000 and cmp 0, or 111 and 1.
// - with cmp 1 the fractional codes protect the complement of the plain area.
// - cmp 1, upper bits 10: all protected except top 4, 8, 16, 32 KB.
// - cmp 1, upper bits 11: all protected except bottom 4, 8, 16, 32 KB.
// - complement_flag is a non-volatile bit at status bit 14, default 0.
// - status bytes keep the documented bit order for every field.
// - lock_mode 00 lets a status write through when write_latch is 1 and no operation runs or is held.
// - lock_mode 11 refuses every status write forever.
// - quad_on reads 1 always, writes ignored, upper data pins stay enabled.
// - secreg_lock bits default 0, set one by one, never clear again.
// - suspend sets erase_held or program_held for the suspended kind; both read-only.
// - resume, software reset pair and power cycle clear both held flags.
// - write_latch clears on power up, reset, lock, status write, program, erase.
// - with cmp 0 the fractional codes protect the plain area directly.
// - status write, program, erase, unlock and lock ending off a byte boundary are rejected and not executed.
`timescale 1ns/1ps
module fsp_regs #(
   parameter int ADDR_W = 24
) (
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic        cmd_valid,
   input  wire logic [7:0]  cmd_code,
   input  wire logic [23:0] cmd_addr,
   input  wire logic        cmd_aligned,
   input  wire logic [7:0]  cmd_data_low,
   input  wire logic [7:0]  cmd_data_high,
   input  wire logic        cmd_two_bytes,
   input  wire logic        op_done,
   input  wire logic [15:0] nv_image,
   output logic [7:0]       status_word_low,
   output logic [7:0]       status_word_high,
   output logic             op_go,
   output logic [1:0]       op_kind,
   output logic             op_refused,
   output logic             op_abort,
   output logic             array_hold,
   output logic [2:0]       secreg_read_only,
   output logic             upper_pins_en,
   output logic             nv_save,
   output logic [15:0]      nv_value
);

   // ****************************************
   // elaboration check
   // ****************************************
   if (ADDR_W != 24)
   begin : g_bad_addr
      $error("fsp_regs serves 24-bit addressing only");
   end

   fsp_pkg::fsp_state_s  cur;
   fsp_pkg::fsp_state_s  next_cur;
   fsp_pkg::fsp_range_s  plain;
   fsp_pkg::fsp_range_s  prot;
   logic [12:0]          frac;
   logic [12:0]          span_lo;
   logic [12:0]          span_hi;
   logic                 overlap;
   logic                 is_prog;
   logic                 is_erase;
   logic                 is_array;
   logic                 is_status;
   logic                 needs_align;
   logic                 array_ok;
   logic                 lock_free;

   // ****************************************
   // protected range decode
   // ****************************************
   always_comb
   begin
      // plain area, as with complement off
      if (!cur.psel[4])
      begin
         frac = fsp_pkg::FRAC_BASE << (cur.psel[2:0] - 3'h1);
      end
      else
      begin
         case (cur.psel[2:0])
            3'h1:    frac = 13'h0001;
            3'h2:    frac = 13'h0002;
            3'h3:    frac = 13'h0004;
            default: frac = 13'h0008;
         endcase
      end
      plain.en = (cur.psel[2:0] != 3'h0);
      if (cur.psel[2:0] == 3'h7)
      begin
         plain.lo = 13'h0000;
         plain.hi = fsp_pkg::LAST_SECTOR;
      end
      else if (!cur.psel[3])
      begin
         plain.lo = fsp_pkg::SECTORS - frac;
         plain.hi = fsp_pkg::LAST_SECTOR;
      end
      else
      begin
         plain.lo = 13'h0000;
         plain.hi = frac - 13'h0001;
      end
      // complement swaps protected and free parts
      prot = plain;
      if (cur.cmp)
      begin
         if (!plain.en)
         begin
            prot.en = 1'b1;
            prot.lo = 13'h0000;
            prot.hi = fsp_pkg::LAST_SECTOR;
         end
         else if (plain.lo == 13'h0000 && plain.hi == fsp_pkg::LAST_SECTOR)
         begin
            prot.en = 1'b0;
         end
         else if (plain.hi == fsp_pkg::LAST_SECTOR)
         begin
            prot.lo = 13'h0000;
            prot.hi = plain.lo - 13'h0001;
         end
         else
         begin
            prot.lo = plain.hi + 13'h0001;
            prot.hi = fsp_pkg::LAST_SECTOR;
         end
      end
   end

   // ****************************************
   // command classification
   // ****************************************
   always_comb
   begin
      is_status = (cmd_code == fsp_pkg::CMD_STATUS_WRITE);
      is_prog   = (cmd_code == fsp_pkg::CMD_PAGE_WRITE) || (cmd_code == fsp_pkg::CMD_QUAD_PAGE);
      is_array  = (cmd_code == fsp_pkg::CMD_ARRAY_WIPE_A) || (cmd_code == fsp_pkg::CMD_ARRAY_WIPE_B);
      is_erase  = (cmd_code == fsp_pkg::CMD_FOUR_K_WIPE) || (cmd_code == fsp_pkg::CMD_WIPE_32K)
                  || (cmd_code == fsp_pkg::CMD_WIPE_64K) || is_array;
      needs_align = is_status || is_prog || is_erase
                    || (cmd_code == fsp_pkg::CMD_WRITE_UNLOCK) || (cmd_code == fsp_pkg::CMD_WRITE_LOCK);
      // sectors touched by the addressed unit
      span_lo = {1'b0, cmd_addr[23:12]};
      span_hi = {1'b0, cmd_addr[23:12]};
      if (cmd_code == fsp_pkg::CMD_WIPE_32K)
      begin
         span_lo = {1'b0, cmd_addr[23:15], 3'h0};
         span_hi = {1'b0, cmd_addr[23:15], 3'h7};
      end
      else if (cmd_code == fsp_pkg::CMD_WIPE_64K)
      begin
         span_lo = {1'b0, cmd_addr[23:16], 4'h0};
         span_hi = {1'b0, cmd_addr[23:16], 4'hF};
      end
      overlap   = prot.en && (span_lo <= prot.hi) && (span_hi >= prot.lo);
      array_ok  = (cur.psel[2:0] == 3'h0 && !cur.cmp) || (cur.psel[2:0] == 3'h7 && cur.cmp);
      lock_free = !cur.lock_hi;
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb
   begin
      next_cur         = cur;
      next_cur.go      = 1'b0;
      next_cur.refused = 1'b0;
      next_cur.abort   = 1'b0;
      next_cur.save    = 1'b0;
      if (!cur.loaded)
      begin
         // non-volatile image is caught after release; power-down lock falls back
         next_cur.loaded  = 1'b1;
         next_cur.psel    = nv_image[fsp_pkg::BIT_PSEL_LO +: 5];
         next_cur.cmp     = nv_image[fsp_pkg::BIT_COMPLEMENT];
         next_cur.lb      = nv_image[fsp_pkg::BIT_SECREG_LO +: 3];
         next_cur.lock_hi = nv_image[fsp_pkg::BIT_LOCK_HIGH] & nv_image[fsp_pkg::BIT_LOCK_LOW];
         next_cur.lock_lo = nv_image[fsp_pkg::BIT_LOCK_HIGH] & nv_image[fsp_pkg::BIT_LOCK_LOW];
      end
      else
      begin
         if (cur.mode == fsp_pkg::FSP_RUN && op_done)
         begin
            next_cur.mode = fsp_pkg::FSP_IDLE;
         end
         if (cmd_valid)
         begin
            next_cur.rst_armed = (cmd_code == fsp_pkg::CMD_RESET_ARM);
            if (needs_align && !cmd_aligned)
            begin
               next_cur.refused = 1'b1;
            end
            else if (cmd_code == fsp_pkg::CMD_RESET_GO && cur.rst_armed)
            begin
               next_cur.mode       = fsp_pkg::FSP_IDLE;
               next_cur.latch      = 1'b0;
               next_cur.erase_held = 1'b0;
               next_cur.prog_held  = 1'b0;
               next_cur.abort      = 1'b1;
            end
            else if (cmd_code == fsp_pkg::CMD_WRITE_UNLOCK)
            begin
               next_cur.latch = 1'b1;
            end
            else if (cmd_code == fsp_pkg::CMD_WRITE_LOCK)
            begin
               next_cur.latch = 1'b0;
            end
            else if (cmd_code == fsp_pkg::CMD_SUSPEND)
            begin
               if (cur.mode == fsp_pkg::FSP_RUN && !op_done && cur.kind != fsp_pkg::FSP_OP_STATUS)
               begin
                  next_cur.mode       = fsp_pkg::FSP_HELD;
                  next_cur.erase_held = (cur.kind == fsp_pkg::FSP_OP_ERASE);
                  next_cur.prog_held  = (cur.kind == fsp_pkg::FSP_OP_PROG);
               end
            end
            else if (cmd_code == fsp_pkg::CMD_RESUME)
            begin
               if (cur.mode == fsp_pkg::FSP_HELD)
               begin
                  next_cur.mode       = fsp_pkg::FSP_RUN;
                  next_cur.erase_held = 1'b0;
                  next_cur.prog_held  = 1'b0;
               end
            end
            else if (is_status || is_prog || is_erase)
            begin
               // any aligned write-class command spends the latch, taken or not
               next_cur.latch = 1'b0;
               if (!cur.latch || cur.mode != fsp_pkg::FSP_IDLE)
               begin
                  next_cur.refused = 1'b1;
               end
               else if (is_status && !lock_free)
               begin
                  next_cur.refused = 1'b1;
               end
               else if ((is_array && !array_ok) || (!is_array && !is_status && overlap))
               begin
                  next_cur.refused = 1'b1;
               end
               else
               begin
                  next_cur.go   = 1'b1;
                  next_cur.mode = fsp_pkg::FSP_RUN;
                  next_cur.kind = is_status ? fsp_pkg::FSP_OP_STATUS
                                : is_prog ? fsp_pkg::FSP_OP_PROG : fsp_pkg::FSP_OP_ERASE;
                  if (is_status)
                  begin
                     // busy, latch, held flags and quad are not taken from the data
                     next_cur.save    = 1'b1;
                     next_cur.psel    = cmd_data_low[fsp_pkg::BIT_PSEL_LO +: 5];
                     next_cur.lock_lo = cmd_data_low[fsp_pkg::BIT_LOCK_LOW];
                     if (cmd_two_bytes)
                     begin
                        next_cur.lock_hi = cmd_data_high[fsp_pkg::BIT_LOCK_HIGH - 8];
                        next_cur.cmp     = cmd_data_high[fsp_pkg::BIT_COMPLEMENT - 8];
                        next_cur.lb      = cur.lb | cmd_data_high[fsp_pkg::BIT_SECREG_LO - 8 +: 3];
                     end
                  end
               end
            end
         end
      end
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cur            <= '0;
         cur.mode       <= fsp_pkg::FSP_IDLE;
         cur.kind       <= fsp_pkg::FSP_OP_STATUS;
         cur.psel       <= fsp_pkg::PSEL_RESET;
         cur.cmp        <= fsp_pkg::CMP_RESET;
         cur.lb         <= fsp_pkg::LB_RESET;
      end
      else
      begin
         cur <= next_cur;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   always_comb
   begin
      status_word_low  = {cur.lock_lo, cur.psel, cur.latch, cur.mode == fsp_pkg::FSP_RUN};
      status_word_high = {cur.erase_held, cur.cmp, cur.lb, cur.prog_held, 1'b1, cur.lock_hi};
   end

   assign op_go            = cur.go;
   assign op_kind          = cur.kind;
   assign op_refused       = cur.refused;
   assign op_abort         = cur.abort;
   assign array_hold       = (cur.mode == fsp_pkg::FSP_HELD);
   assign secreg_read_only = cur.lb;
   assign upper_pins_en    = status_word_high[fsp_pkg::BIT_QUAD - 8];
   assign nv_save          = cur.save;
   assign nv_value         = {status_word_high, status_word_low};

   // ****************************************
   // checks
   // ****************************************
   latch_gate_a: assert property (@(posedge core_clk) disable iff (!rstn)
      cmd_valid && (is_status || is_prog || is_erase) && !cur.latch && cur.loaded |=> !op_go)
      else $error("write-class command ran without latch");
   latch_spent_a: assert property (@(posedge core_clk) disable iff (!rstn)
      cmd_valid && cmd_aligned && (is_status || is_prog || is_erase) && cur.loaded |=> !status_word_low[1])
      else $error("latch survived a write-class command");
   busy_track_a: assert property (@(posedge core_clk) disable iff (!rstn)
      op_go |-> status_word_low[0] && $past(!status_word_low[0]))
      else $error("busy not raised with a started operation");
   lock_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
      cur.lock_hi && cur.lock_lo && cur.loaded |=> cur.lock_hi && $stable(status_word_low[6:2]))
      else $error("locked status register changed");
   quad_fixed_a: assert property (@(posedge core_clk) disable iff (!rstn)
      status_word_high[1] && upper_pins_en)
      else $error("quad bit dropped");
   secreg_sticky_a: assert property (@(posedge core_clk) disable iff (!rstn)
      cur.loaded |=> (cur.lb & $past(cur.lb)) == $past(cur.lb))
      else $error("security lock bit cleared");
   resume_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
      cmd_valid && cmd_code == fsp_pkg::CMD_RESUME && array_hold && cur.loaded
      |=> !status_word_high[7] && !status_word_high[2] && status_word_low[0])
      else $error("resume left a held flag");
   array_gate_a: assert property (@(posedge core_clk) disable iff (!rstn)
      cmd_valid && cmd_aligned && is_array && !array_ok && cur.loaded |=> !op_go ##1 !op_go)
      else $error("array erase ran while protected");
   prot_block_a: assert property (@(posedge core_clk) disable iff (!rstn)
      cmd_valid && (is_prog || (is_erase && !is_array)) && overlap && cur.loaded |=> !op_go)
      else $error("write into protected area started");
   align_reject_a: assert property (@(posedge core_clk) disable iff (!rstn)
      cmd_valid && needs_align && !cmd_aligned && cur.loaded |=> op_refused && !op_go)
      else $error("unaligned command not rejected");

endmodule // fsp_regs

//--- logic/fsp_pkg.sv
// Purpose: shared constants and types of the flash status and protection block
// Assumes: 24-bit byte addresses, 4 KB sectors, 16 MB array
// Notes:   command codes are the serial opcodes seen by the decoder
package fsp_pkg;

   // ****************************************
   // command opcodes
   // ****************************************
   localparam logic [7:0] CMD_WRITE_UNLOCK = 8'h06;
   localparam logic [7:0] CMD_WRITE_LOCK   = 8'h04;
   localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
   localparam logic [7:0] CMD_PAGE_WRITE   = 8'h02;
   localparam logic [7:0] CMD_QUAD_PAGE    = 8'h32;
   localparam logic [7:0] CMD_FOUR_K_WIPE  = 8'h20;
   localparam logic [7:0] CMD_WIPE_32K     = 8'h52;
   localparam logic [7:0] CMD_WIPE_64K     = 8'hD8;
   localparam logic [7:0] CMD_ARRAY_WIPE_A = 8'h60;
   localparam logic [7:0] CMD_ARRAY_WIPE_B = 8'hC7;
   localparam logic [7:0] CMD_SUSPEND      = 8'h75;
   localparam logic [7:0] CMD_RESUME       = 8'h7A;
   localparam logic [7:0] CMD_RESET_ARM    = 8'h66;
   localparam logic [7:0] CMD_RESET_GO     = 8'h99;

   // ****************************************
   // status bit positions (low byte 0..7, high byte 8..15)
   // ****************************************
   localparam int BIT_BUSY       = 0;
   localparam int BIT_LATCH      = 1;
   localparam int BIT_PSEL_LO    = 2;
   localparam int BIT_LOCK_LOW   = 7;
   localparam int BIT_LOCK_HIGH  = 8;
   localparam int BIT_QUAD       = 9;
   localparam int BIT_PROG_HELD  = 10;
   localparam int BIT_SECREG_LO  = 11;
   localparam int BIT_COMPLEMENT = 14;
   localparam int BIT_ERASE_HELD = 15;

   // ****************************************
   // reset values and array geometry
   // ****************************************
   localparam logic [4:0]  PSEL_RESET   = 5'h00;
   localparam logic        CMP_RESET    = 1'b0;
   localparam logic [2:0]  LB_RESET     = 3'h0;
   localparam logic [12:0] SECTORS      = 13'h1000;
   localparam logic [12:0] LAST_SECTOR  = 13'h0FFF;
   localparam logic [12:0] FRAC_BASE    = 13'h0040;

   typedef enum logic [2:0] {
      FSP_IDLE = 3'b001,
      FSP_RUN  = 3'b010,
      FSP_HELD = 3'b100
   } fsp_mode_e;

   typedef enum logic [1:0] {
      FSP_OP_STATUS = 2'h0,
      FSP_OP_PROG   = 2'h1,
      FSP_OP_ERASE  = 2'h2
   } fsp_op_e;

   typedef struct packed {
      logic        en;
      logic [12:0] lo;
      logic [12:0] hi;
   } fsp_range_s;

   typedef struct packed {
      fsp_mode_e   mode;
      fsp_op_e     kind;
      logic        loaded;
      logic        latch;
      logic [4:0]  psel;
      logic        lock_lo;
      logic        lock_hi;
      logic        cmp;
      logic [2:0]  lb;
      logic        erase_held;
      logic        prog_held;
      logic        rst_armed;
      logic        go;
      logic        refused;
      logic        abort;
      logic        save;
   } fsp_state_s;

endpackage

//--- sim/fsp_host.sv
// Purpose: host command source, array engine and non-volatile store beside the status block
// Assumes: commands are presented whole, one per call of send
// Notes:   lat sets how slowly the array engine finishes; the bench changes it
`timescale 1ns/1ps
module fsp_host (
   input  wire logic        core_clk,
   input  wire logic        op_go,
   input  wire logic        op_abort,
   input  wire logic        array_hold,
   input  wire logic        nv_save,
   input  wire logic [15:0] nv_value,
   output logic             cmd_valid,
   output logic [7:0]       cmd_code,
   output logic [23:0]      cmd_addr,
   output logic             cmd_aligned,
   output logic [7:0]       cmd_data_low,
   output logic [7:0]       cmd_data_high,
   output logic             cmd_two_bytes,
   output logic             op_done,
   output logic [15:0]      nv_image
);
   int lat = 2;
   int cnt = 0;
   initial
   begin
      {cmd_valid, cmd_code, cmd_addr, cmd_aligned} = '0;
      {cmd_data_low, cmd_data_high, cmd_two_bytes, op_done, nv_image} = '0;
   end
   // one command for one cycle; data lines scrambled once released
   task automatic send(input logic [7:0] c, input logic [23:0] a, input logic [15:0] d, input logic al,
                       input logic two);
      @(negedge core_clk);
      cmd_valid = 1'b1;
      cmd_code = c;
      cmd_addr = a;
      {cmd_data_high, cmd_data_low} = d;
      cmd_two_bytes = two;
      cmd_aligned = al;
      @(negedge core_clk);
      cmd_valid = 1'b0;
      cmd_addr = ~a;
      {cmd_data_high, cmd_data_low} = ~d;
      cmd_aligned = ~al;
   endtask
   // array engine: counting stops while the operation is held
   always @(negedge core_clk)
   begin
      op_done <= 1'b0;
      if (op_abort)
         cnt = 0;
      else if (op_go)
         cnt = lat;
      else if (cnt > 0 && !array_hold)
      begin
         cnt--;
         if (cnt == 0)
            op_done <= 1'b1;
      end
      if (nv_save)
         nv_image <= nv_value;
   end
endmodule // fsp_host

//--- sim/flash_status_protection_tb.sv
// Purpose: self-checking bench of the flash status and protection block
// Assumes: fsp_host drives commands, finishes operations and keeps the stored image
// Notes:   protection cases are table rows; reset, locks and suspend are hand-written
`timescale 1ns/1ps
module flash_status_protection_tb;
   typedef struct {logic cmp; logic [4:0] ps; logic [7:0] c; logic [23:0] a; logic go;} fsp_row_s;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic cmd_valid, cmd_aligned, cmd_two_bytes, op_done, op_go, op_refused, op_abort;
   logic array_hold, upper_pins_en, nv_save;
   logic [7:0] cmd_code, cmd_data_low, cmd_data_high, status_word_low, status_word_high;
   logic [23:0] cmd_addr;
   logic [15:0] nv_image, nv_value, st;
   logic [1:0] op_kind;
   logic [2:0] secreg_read_only;
   logic [1:0] kind_exp;
   int fail_count = 0;
   int compares = 0;
   int cyc = 0;
   fsp_row_s rows[19] = '{
      '{0,5'h01,8'h20,24'hFC0000,0}, '{0,5'h01,8'h52,24'hFB8000,1}, '{1,5'h01,8'h02,24'hFC0000,1},
      '{1,5'h01,8'h02,24'hFBFFFF,0}, '{1,5'h09,8'h20,24'h03F000,1}, '{1,5'h09,8'h32,24'h040000,0},
      '{1,5'h14,8'h20,24'hFF8000,1}, '{1,5'h15,8'h20,24'hFF7000,0}, '{1,5'h16,8'h20,24'hFF8000,1},
      '{1,5'h19,8'h20,24'h000000,1}, '{1,5'h19,8'hD8,24'h000000,0}, '{1,5'h1E,8'h52,24'h000000,1},
      '{1,5'h1C,8'h20,24'h008000,0}, '{0,5'h00,8'h60,24'h0,1}, '{0,5'h08,8'hC7,24'h0,1},
      '{1,5'h07,8'h60,24'h0,1}, '{1,5'h00,8'hC7,24'h0,0}, '{0,5'h01,8'h60,24'h0,0},
      '{0,5'h11,8'hC7,24'h0,0}};
   assign st = {status_word_high, status_word_low};
   always #5 core_clk = ~core_clk;
   fsp_regs i_fsp_regs (.core_clk(core_clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_addr(cmd_addr), .cmd_aligned(cmd_aligned), .cmd_data_low(cmd_data_low),
      .cmd_data_high(cmd_data_high), .cmd_two_bytes(cmd_two_bytes), .op_done(op_done), .nv_image(nv_image),
      .status_word_low(status_word_low), .status_word_high(status_word_high), .op_go(op_go),
      .op_kind(op_kind), .op_refused(op_refused), .op_abort(op_abort), .array_hold(array_hold),
      .secreg_read_only(secreg_read_only), .upper_pins_en(upper_pins_en), .nv_save(nv_save),
      .nv_value(nv_value));
   fsp_host i_fsp_host (.core_clk(core_clk), .op_go(op_go), .op_abort(op_abort), .array_hold(array_hold),
      .nv_save(nv_save), .nv_value(nv_value), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_addr(cmd_addr), .cmd_aligned(cmd_aligned), .cmd_data_low(cmd_data_low),
      .cmd_data_high(cmd_data_high), .cmd_two_bytes(cmd_two_bytes), .op_done(op_done), .nv_image(nv_image));
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic end_of_test;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk_w(input string n, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e)
      begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_b(input string n, input logic e, input logic g);
      compares++;
      if (g !== e)
      begin
         fail_count++;
         $display("FAIL %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic cmd(input logic [7:0] c, input logic [23:0] a = 24'h0, input logic [15:0] d = 16'h0,
                      input logic al = 1'b1, input logic two = 1'b1);
      i_fsp_host.send(c, a, d, al, two);
   endtask
   // bounded so a stuck busy flag cannot hang the run
   task automatic wait_idle;
      int n;
      n = 0;
      while (st[0] !== 1'b0 && n < 200)
      begin
         @(negedge core_clk);
         n++;
      end
      chk_b("idle", 1'b1, n < 200);
   endtask
   task automatic status_write_cmd(input logic [15:0] d);
      cmd(8'h06);
      cmd(8'h01, 24'h0, d);
      wait_idle();
   endtask
   task automatic do_reset(input logic [15:0] v);
      rstn = 1'b0;
      i_fsp_host.nv_image = v;
      repeat (3) @(negedge core_clk);
      rstn = 1'b1;
      @(negedge core_clk);
   endtask
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         end_of_test();
      end
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      do_reset(16'h0);
      chk_w("reset", 16'h0200, st);
      chk_b("pins", 1'b1, upper_pins_en);
      foreach (rows[i])
      begin
         i_fsp_host.lat = 1 + i % 5;
         status_write_cmd({1'b0, rows[i].cmp, 6'h00, 1'b0, rows[i].ps, 2'b00});
         chk_w("status", {1'b0, rows[i].cmp, 6'h02, 1'b0, rows[i].ps, 2'b00}, st);
         cmd(8'h06);
         cmd(rows[i].c, rows[i].a);
         chk_b("go", rows[i].go, op_go);
         kind_exp = !rows[i].go ? 2'h0 : (rows[i].c == 8'h02 || rows[i].c == 8'h32) ? 2'h1 : 2'h2;
         chk_w("kind", {14'h0, kind_exp}, {14'h0, op_kind});
         chk_b("latch", 1'b0, st[1]);
         wait_idle();
      end
      // refusals without latch and off a byte boundary; lock clears the latch
      status_write_cmd(16'h0);
      cmd(8'h01, 24'h0, 16'h0004);
      chk_b("nolatch", 1'b1, op_refused);
      cmd(8'h02);
      chk_b("noprog", 1'b1, op_refused);
      cmd(8'h06);
      cmd(8'h04);
      chk_b("lock", 1'b0, st[1]);
      cmd(8'h06);
      cmd(8'h01, 24'h0, 16'h0004, 1'b0);
      chk_b("unaligned", 1'b1, op_refused);
      // read-only fields ignore written data
      status_write_cmd(16'h8407);
      chk_w("readonly", 16'h0204, st);
      // a one-byte status write must leave the high byte alone
      cmd(8'h06);
      cmd(8'h01, 24'h0, 16'h4000, 1'b1, 1'b0);
      wait_idle();
      chk_w("onebyte", 16'h0200, st);
      // security locks only accumulate
      status_write_cmd(16'h0800);
      status_write_cmd(16'h1000);
      status_write_cmd(16'h0000);
      chk_w("secreg", 16'h1A00, st);
      chk_w("secro", 16'h0003, {13'h0, secreg_read_only});
      // suspend and resume an erase, then abort a held program
      i_fsp_host.lat = 20;
      cmd(8'h06);
      cmd(8'h20, 24'h001000);
      chk_b("busy", 1'b1, st[0]);
      cmd(8'h75);
      chk_w("eheld", 16'h9A00, st);
      chk_b("hold", 1'b1, array_hold);
      cmd(8'h7A);
      chk_w("resume", 16'h1A01, st);
      wait_idle();
      cmd(8'h06);
      cmd(8'h02, 24'h000100);
      cmd(8'h75);
      chk_b("pheld", 1'b1, st[10]);
      cmd(8'h66);
      cmd(8'h99);
      chk_b("abort", 1'b1, op_abort);
      chk_b("pclear", 1'b0, st[10]);
      wait_idle();
      // lock-down until power cycle, then permanent lock
      i_fsp_host.lat = 1;
      status_write_cmd(16'h0100);
      cmd(8'h06);
      cmd(8'h01);
      chk_b("lockdown", 1'b1, op_refused);
      do_reset(i_fsp_host.nv_image);
      chk_b("unlock", 1'b0, st[8]);
      status_write_cmd(16'h0004);
      chk_w("accept", 16'h1A04, st);
      do_reset(16'h0180);
      chk_w("otp", 16'h0380, st);
      cmd(8'h06);
      cmd(8'h01);
      chk_b("otpref", 1'b1, op_refused);
      end_of_test();
   end
endmodule // flash_status_protection_tb
